//--- logic/isr_resolver.sv
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"
module isr_resolver
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic [31:0]           adr_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    input  wire logic                  we_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    output logic                       ack_o,
    output logic                       err_o,
    input  wire isr_pkg::isr_req_type  [7:0] idle_req_i,
    input  wire isr_pkg::isr_io_type   [7:0] io_read_i,
    input  wire logic [7:0]            intr_i,
    input  wire logic [7:0]            intr_unmasked_i,
    input  wire logic [3:0]            break_i,
    input  wire logic [3:0]            break_masked_i,
    input  wire logic [7:0]            flush_done_i,
    output logic      [7:0]            io_redirect_o,
    output logic      [7:0]            io_fallthru_o,
    output logic      [7:0]            thr_sleep_o,
    output logic      [3:0]            repartition_o,
    output logic      [3:0]            flush_req_o,
    output logic      [3:0]            core_active_o,
    output logic      [7:0]            core_state_o,
    output logic      [1:0]            pkg_state_o,
    output logic                       vf_min_o,
    output logic                       vret_o,
    output logic                       pll_relock_o,
    output logic      [3:0]            break_fwd_o,
    output logic      [7:0]            resume_pstate_o,
    output logic                       smi_o
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [1:0] min2(input logic [1:0] a,
                                        input logic [1:0] b,
                                        input logic ea,
                                        input logic eb);
        logic [1:0] r;
        r = 2'h3;
        if (ea)
        begin
            r = a;
        end
        if (eb && (!ea || b < a))
        begin
            r = b;
        end
        return r;
    endfunction

    // demote hint to supported state; c1 sub-state 1 means c1e
    function automatic logic [1:0] hint_map(input logic [3:0] st,
                                            input logic [3:0] sub,
                                            input logic c1e_all);
        logic [1:0] r;
        r = 2'h1;
        if (st >= `ISR_HINT_C3)
        begin
            r = 2'h3;
        end
        else if (sub == `ISR_HINT_C1E_SUB || c1e_all)
        begin
            r = 2'h2;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] iocap_q;
    logic [7:0]  core_en_q;
    logic [7:0]  thr_en_q;
    logic [7:0]  pstate_q;
    logic        ack_q;
    logic        hit;
    logic [31:0] rd;
    logic        wr;

    always_comb
    begin
        hit = 1'b1;
        rd  = 32'h0000_0000;
        case (adr_i[7:0])
            `ISR_ADDR_CTRL:      rd = ctrl_q;
            `ISR_ADDR_IOCAP:     rd = iocap_q;
            `ISR_ADDR_CORE_EN:   rd = {28'h0000_000, core_en_q[3:0]};
            `ISR_ADDR_THR_EN:    rd = {24'h00_0000, thr_en_q};
            `ISR_ADDR_PKG_STAT:  rd = {24'h00_0000, vf_min_o, vret_o,
                                       pll_relock_o, 3'h0, pkg_state_o};
            `ISR_ADDR_CORE_STAT: rd = {20'h0_0000, core_active_o,
                                       core_state_o};
            `ISR_ADDR_THR_STAT:  rd = {24'h00_0000, thr_sleep_o};
            `ISR_ADDR_PSTATE:    rd = {24'h00_0000, pstate_q};
            default:             hit = 1'b0;
        endcase
        if (adr_i[31:8] != 24'h00_0000)
        begin
            hit = 1'b0;
        end
    end

    // write lands on the edge where the master samples ack high
    assign wr    = cyc_i && stb_i && we_i && ack_q && hit && ce_i;
    assign ack_o = ack_q && cyc_i && stb_i && hit;
    assign err_o = ack_q && cyc_i && stb_i && !hit;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_q <= cyc_i && stb_i && !ack_q;
            dat_o <= rd;
        end
    end

    function automatic logic [31:0] bytew(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q    <= `ISR_CTRL_RST;
            iocap_q   <= `ISR_IOCAP_RST;
            core_en_q <= `ISR_EN_RST;
            thr_en_q  <= `ISR_EN_RST;
            pstate_q  <= `ISR_PSTATE_RST;
        end
        else if (wr)
        begin
            case (adr_i[7:0])
                `ISR_ADDR_CTRL:    ctrl_q  <= bytew(ctrl_q, dat_i, sel_i);
                `ISR_ADDR_IOCAP:   iocap_q <= bytew(iocap_q, dat_i, sel_i);
                `ISR_ADDR_CORE_EN: if (sel_i[0]) core_en_q <= dat_i[7:0];
                `ISR_ADDR_THR_EN:  if (sel_i[0]) thr_en_q <= dat_i[7:0];
                `ISR_ADDR_PSTATE:  if (sel_i[0]) pstate_q <= dat_i[7:0];
                default:           ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // thread requests
    // ------------------------------------------------------------
    logic [1:0] thr_q [8];
    logic [1:0] tgt   [8];
    logic [7:0] go;

    always_comb
    begin
        for (int t = 0; t < 8; t++)
        begin
            logic [15:0] off;
            off = io_read_i[t].addr - iocap_q[15:0];
            tgt[t] = 2'h0;
            go[t]  = 1'b0;
            io_redirect_o[t] = 1'b0;
            io_fallthru_o[t] = 1'b0;
            if (idle_req_i[t].valid)
            begin
                go[t] = 1'b1;
                tgt[t] = idle_req_i[t].is_monitor_wait_instruction
                    ? hint_map(idle_req_i[t].hint_state,
                               idle_req_i[t].hint_sub,
                               ctrl_q[`ISR_CTRL_C1E_ALL])
                    : (ctrl_q[`ISR_CTRL_C1E_ALL] ? 2'h2 : 2'h1);
            end
            else if (io_read_i[t].valid)
            begin
                // base is c2 and c2 is unsupported, so only base+1 is c3
                if (io_read_i[t].is_in && !io_read_i[t].is_rep
                    && off == 16'h0001
                    && {13'h0000, iocap_q[18:16]} >= off)
                begin
                    go[t] = 1'b1;
                    tgt[t] = 2'h3;
                    io_redirect_o[t] = 1'b1;
                end
                else
                begin
                    io_fallthru_o[t] = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // thread state and wake
    // ------------------------------------------------------------
    logic [3:0] flushing_q;
    logic [3:0] flush_step_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int t = 0; t < 8; t++)
            begin
                thr_q[t] <= 2'h0;
            end
        end
        else if (ce_i)
        begin
            for (int t = 0; t < 8; t++)
            begin
                if (thr_q[t] == 2'h0 && go[t])
                begin
                    thr_q[t] <= tgt[t];
                end
                else if (thr_q[t] != 2'h0
                         && ((intr_i[t] && intr_unmasked_i[t])
                             || break_fwd_o[t/2])
                         && !flushing_q[t/2])
                begin
                    thr_q[t] <= 2'h0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // core resolution, flush, active bits
    // ------------------------------------------------------------
    logic [1:0] core_st [4];
    logic [3:0] core_c3;

    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            core_st[c] = min2(thr_q[2*c], thr_q[2*c+1], thr_en_q[2*c],
                              thr_en_q[2*c+1]);
            core_state_o[2*c +: 2] = core_st[c];
            thr_sleep_o[2*c]   = thr_q[2*c] != 2'h0;
            thr_sleep_o[2*c+1] = thr_q[2*c+1] != 2'h0;
            // counts only once its flush has run, not on the entry cycle
            core_c3[c] = core_st[c] == 2'h3 && !flushing_q[c]
                         && !core_active_o[c];
            // first of the pair to leave c0 into c1/c1e
            repartition_o[c] = (go[2*c] && thr_q[2*c+1] == 2'h0
                                && thr_q[2*c] == 2'h0 && tgt[2*c] != 2'h3)
                            || (go[2*c+1] && thr_q[2*c] == 2'h0
                                && thr_q[2*c+1] == 2'h0
                                && tgt[2*c+1] != 2'h3);
        end
    end

    assign flush_req_o = flushing_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flushing_q   <= 4'h0;
            flush_step_q <= 4'h0;
        end
        else if (ce_i)
        begin
            for (int c = 0; c < 4; c++)
            begin
                if (!flushing_q[c] && core_active_o[c] && core_st[c] == 2'h3)
                begin
                    flushing_q[c] <= 1'b1;
                end
                else if (flushing_q[c] && flush_done_i[2*c])
                begin
                    // two steps, one per flush_done_i ack; break does not abort
                    if (flush_step_q[c])
                    begin
                        flushing_q[c] <= 1'b0;
                    end
                    flush_step_q[c] <= ~flush_step_q[c];
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_active_o   <= 4'hf;
            resume_pstate_o <= `ISR_PSTATE_RST;
        end
        else if (ce_i)
        begin
            for (int c = 0; c < 4; c++)
            begin
                if (core_st[c] == 2'h0 && !core_active_o[c])
                begin
                    core_active_o[c] <= 1'b1;
                    resume_pstate_o  <= pstate_q;
                end
                else if (core_st[c] != 2'h0 && !flushing_q[c])
                begin
                    core_active_o[c] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // package sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PK_RUN, PK_RET, PK_VUP, PK_LOCK, PK_FWD
    } pk_state_type;
    pk_state_type pk_q;
    logic [7:0]   cnt_q;
    logic [1:0]   pk_res;
    logic         all_c3;

    always_comb
    begin
        logic [1:0] a;
        logic [1:0] b;
        logic       ea;
        logic       eb;
        a  = min2(core_st[0], core_st[1], core_en_q[0], core_en_q[1]);
        b  = min2(core_st[2], core_st[3], core_en_q[2], core_en_q[3]);
        ea = core_en_q[0] | core_en_q[1];
        eb = core_en_q[2] | core_en_q[3];
        pk_res = min2(a, b, ea, eb);
        all_c3 = pk_res == 2'h3
                 && ((core_c3 | ~core_en_q[3:0]) == 4'hf);
    end

    assign pkg_state_o  = pk_res;
    assign vf_min_o     = pk_res == 2'h2 || pk_q != PK_RUN;
    assign vret_o       = pk_q == PK_RET;
    assign pll_relock_o = pk_q == PK_LOCK;
    assign smi_o        = 1'b0;

    always_comb
    begin
        break_fwd_o = 4'h0;
        if (pk_q == PK_FWD)
        begin
            break_fwd_o = break_i & ~break_masked_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pk_q  <= PK_RUN;
            cnt_q <= 8'h00;
        end
        else if (ce_i)
        begin
            case (pk_q)
                PK_RUN:
                    if (all_c3)
                    begin
                        pk_q <= PK_RET;
                    end
                PK_RET:
                    if (|break_i)
                    begin
                        pk_q  <= PK_VUP;
                        cnt_q <= `ISR_VOLT_CYC;
                    end
                PK_VUP:
                    if (cnt_q == 8'h00)
                    begin
                        pk_q  <= PK_LOCK;
                        cnt_q <= `ISR_LOCK_CYC;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                PK_LOCK:
                    if (cnt_q == 8'h00)
                    begin
                        pk_q <= PK_FWD;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                PK_FWD:
                    // masked break leaves all cores in c3: back to retention
                    pk_q <= (|(break_i & ~break_masked_i)) ? PK_RUN
                                                           : PK_RET;
                default:
                    pk_q <= PK_RUN;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- logic/isr_defs.svh
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH
`define ISR_NCORE          4
`define ISR_NTHR           2
// register byte offsets
`define ISR_ADDR_CTRL      8'h00
`define ISR_ADDR_IOCAP     8'h04
`define ISR_ADDR_CORE_EN   8'h08
`define ISR_ADDR_THR_EN    8'h0c
`define ISR_ADDR_PKG_STAT  8'h10
`define ISR_ADDR_CORE_STAT 8'h14
`define ISR_ADDR_THR_STAT  8'h18
`define ISR_ADDR_PSTATE    8'h1c
// ctrl fields
`define ISR_CTRL_C1E_ALL   0
`define ISR_CTRL_RST       32'h0000_0000
// io capture config: base [15:0], range [18:16]
`define ISR_IOCAP_RST      32'h0000_0000
`define ISR_EN_RST         8'hff
`define ISR_PSTATE_RST     8'h00
// monitor-wait hints (state field; ISR_HINT_C1E_SUB is a sub field value)
`define ISR_HINT_C1        4'h0
`define ISR_HINT_C3        4'h1
`define ISR_HINT_C1E_SUB   4'h1
// flush and power sequencing counts, cycles
`define ISR_FLUSH_CYC      8'h10
`define ISR_VOLT_CYC       8'h20
`define ISR_LOCK_CYC       8'h20
`endif

//--- logic/isr_pkg.sv
package isr_pkg;
    typedef enum logic [1:0] {
        ISR_C0  = 2'h0,
        ISR_C1  = 2'h1,
        ISR_C1E = 2'h2,
        ISR_C3  = 2'h3
    } isr_cstate_type;

    typedef struct packed {
        logic       valid;
        logic       is_monitor_wait_instruction;
        logic [3:0] hint_state;
        logic [3:0] hint_sub;
    } isr_req_type;

    typedef struct packed {
        logic        valid;
        logic        is_in;
        logic        is_rep;
        logic [15:0] addr;
    } isr_io_type;
endpackage

//--- verification/isr_resolver_sva.sv
`timescale 1ns/1ps
`default_nettype none
module isr_resolver_sva
(
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire isr_pkg::isr_io_type [7:0] io_read_i,
    input wire logic [3:0]                break_masked_i,
    input wire logic [7:0]                flush_done_i,
    input wire logic [7:0]                io_redirect_o,
    input wire logic [7:0]                thr_sleep_o,
    input wire logic [3:0]                flush_req_o,
    input wire logic [3:0]                core_active_o,
    input wire logic [7:0]                core_state_o,
    input wire logic [1:0]                pkg_state_o,
    input wire logic                      vf_min_o,
    input wire logic                      vret_o,
    input wire logic                      pll_relock_o,
    input wire logic [3:0]                break_fwd_o,
    input wire logic                      smi_o
);
// ----
// core minimum, all cores enabled in the bench
// ----
logic [1:0] m01;
logic [1:0] m23;
logic [1:0] cmin;
assign m01  = (core_state_o[1:0] < core_state_o[3:2]) ?
              core_state_o[1:0] : core_state_o[3:2];
assign m23  = (core_state_o[5:4] < core_state_o[7:6]) ?
              core_state_o[5:4] : core_state_o[7:6];
assign cmin = (m01 < m23) ? m01 : m23;
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
a_core_min: assert property (!(&thr_sleep_o[1:0])
    |-> core_state_o[1:0] == 2'h0)
    else $error("core not active with awake thread");
a_pkg_min: assert property (pkg_state_o == cmin)
    else $error("package state not core minimum");
a_wake_active: assert property ($fell(thr_sleep_o[0])
    |-> ##[0:1] core_active_o[0])
    else $error("wake left core inactive");
a_active_fall: assert property ($fell(core_active_o[0])
    |-> &thr_sleep_o[1:0])
    else $error("core inactive with awake thread");
a_vf_c1e: assert property ($rose(core_state_o == 8'haa)
    |-> ##[0:3] vf_min_o)
    else $error("no minimum point with all cores c1e");
a_vret_c3: assert property ($rose(core_state_o == 8'hff
    && flush_req_o == 4'h0 && core_active_o == 4'h0) |-> ##[0:3] vret_o)
    else $error("no retention with all cores c3");
a_lock_after_volt: assert property ($rose(pll_relock_o)
    |-> !$past(vret_o, 30))
    else $error("relock before voltage raise");
a_fwd_after_lock: assert property ($rose(break_fwd_o[0])
    |-> $past(pll_relock_o))
    else $error("break forwarded before relock");
a_fwd_masked: assert property ($fell(pll_relock_o)
    && break_fwd_o == 4'h0 |-> ##[1:4] vret_o)
    else $error("masked break did not re-enter retention");
a_fwd_wakes: assert property ($rose(break_fwd_o[0])
    && !break_masked_i[0] |-> ##[1:4] core_state_o[1:0] == 2'h0)
    else $error("unmasked break did not wake core");
a_flush_hold: assert property (flush_req_o[0]
    && !flush_done_i[0] |=> flush_req_o[0])
    else $error("flush abandoned before done");
a_io_single: assert property (io_redirect_o[1]
    |-> io_read_i[1].valid && io_read_i[1].is_in
        && !io_read_i[1].is_rep)
    else $error("redirect on non single read");
a_smi_off: assert property (!smi_o)
    else $error("smi raised");
c_vf_min: cover property (vf_min_o);
c_fwd: cover property ($rose(|break_fwd_o));
c_redirect: cover property (|io_redirect_o);
endmodule
bind isr_resolver isr_resolver_sva u_isr_resolver_sva(.clk_i, .rst_i, .io_read_i,
    .break_masked_i, .flush_done_i, .io_redirect_o, .thr_sleep_o, .flush_req_o,
    .core_active_o, .core_state_o, .pkg_state_o, .vf_min_o, .vret_o,
    .pll_relock_o, .break_fwd_o, .smi_o);
`default_nettype wire

//--- verification/isr_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module isr_far_model
#(
    parameter int DLY = 3
)
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] slow_i,
    input  wire logic [3:0] flush_req_i,
    output logic      [7:0] flush_done_o
);
// ----
// cache flush responder, one ack per step
// ----
logic [3:0] cnt_q [4];
always_ff @(posedge clk_i)
begin
    for (int c = 0; c < 4; c++)
    begin
        flush_done_o[2*c]   <= 1'b0;
        flush_done_o[2*c+1] <= 1'b0;
        if (rst_i || !flush_req_i[c])
            cnt_q[c] <= 4'h0;
        else if (cnt_q[c] >= (slow_i[c] ? DLY[3:0] : 4'h1))
        begin
            cnt_q[c]          <= 4'h0;
            flush_done_o[2*c] <= 1'b1;
        end
        else
            cnt_q[c] <= cnt_q[c] + 4'h1;
    end
end
endmodule
`default_nettype wire

//--- verification/tb_isr_resolver.sv
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"
module tb_isr_resolver;
logic                      clk_i = 1'b0;
logic                      rst_i = 1'b1;
logic                      ce_i = 1'b1;
logic [31:0]               adr_i = 32'h0;
logic [31:0]               dat_i = 32'h0;
logic                      we_i = 1'b0;
logic [3:0]                sel_i = 4'h0;
logic                      cyc_i = 1'b0;
logic                      stb_i = 1'b0;
isr_pkg::isr_req_type [7:0] idle_req_i = '0;
isr_pkg::isr_io_type [7:0]  io_read_i = '0;
logic [7:0]                intr_i = 8'h0;
logic [7:0]                intr_unmasked_i = 8'h0;
logic [3:0]                break_i = 4'h0;
logic [3:0]                break_masked_i = 4'h0;
logic [7:0]                flush_done_i;
logic [31:0]               dat_o;
logic                      ack_o, err_o, vf_min_o, vret_o, pll_relock_o, smi_o;
logic [7:0]                io_redirect_o, io_fallthru_o, thr_sleep_o;
logic [7:0]                core_state_o, resume_pstate_o;
logic [3:0]                repartition_o, flush_req_o, core_active_o;
logic [3:0]                break_fwd_o;
logic [1:0]                pkg_state_o;
logic                      rp_q = 1'b0;
logic [31:0]               q;
logic                      e;
int                        fails = 0;
int                        cmp_count = 0;
always #10 clk_i = ~clk_i;
always @(posedge clk_i)
    if (repartition_o[0] === 1'b1)
        rp_q <= 1'b1;
isr_resolver u_isr_resolver(.*);
isr_far_model u_isr_far_model(.clk_i, .rst_i, .slow_i(4'h3),
    .flush_req_i(flush_req_o), .flush_done_o(flush_done_i));
// ----
// tasks
// ----
task automatic give_verdict;
    if (fails == 0 && cmp_count > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] s,
                   input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
        fails++;
        $display("[FAIL] %s exp %h seen %h", nm, x, s);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'hf;
    adr_i <= {24'h0, a};
    dat_i <= d;
    n = 0;
    do
    begin
        @(posedge clk_i);
        n++;
    end
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50)
    begin
        fails++;
        give_verdict;
    end
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    chk("read data", q, x);
endtask
task automatic reqm(input logic [7:0] m, input logic mw, input logic [3:0] st,
                    input logic [3:0] sb);
    @(posedge clk_i);
    for (int i = 0; i < 8; i++)
        if (m[i])
            idle_req_i[i] <= {1'b1, mw, st, sb};
    @(posedge clk_i);
    idle_req_i <= '0;
    tick(2);
endtask
task automatic io(input logic rep, input logic [15:0] a, input logic rd);
    @(posedge clk_i);
    io_read_i[1] <= {1'b1, 1'b1, rep, a};
    #1;
    chk("redirect", 32'(io_redirect_o[1]), 32'(rd));
    chk("fall through", 32'(io_fallthru_o[1]), 32'(!rd));
    @(posedge clk_i);
    io_read_i[1] <= '0;
endtask
function automatic logic hit(input int k);
    case (k)
        0: return core_state_o === 8'hff;
        1: return break_fwd_o[0] === 1'b1;
        3: return pll_relock_o === 1'b1;
        4: return pll_relock_o === 1'b0;
        default: return vret_o === 1'b1;
    endcase
endfunction
task automatic wt(input int k);
    int n;
    n = 0;
    while (!hit(k) && n < 400)
    begin
        tick(1);
        n++;
    end
    if (n >= 400)
    begin
        fails++;
        give_verdict;
    end
endtask
// ----
// main sequence
// ----
initial
begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`ISR_ADDR_CTRL, `ISR_CTRL_RST);
    rdc(`ISR_ADDR_IOCAP, `ISR_IOCAP_RST);
    rdc(`ISR_ADDR_THR_EN, {24'h0, `ISR_EN_RST});
    rdc(`ISR_ADDR_PSTATE, {24'h0, `ISR_PSTATE_RST});
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'(e), 32'h1);
    wb(1'b1, `ISR_ADDR_PSTATE, 32'h5a);
    rdc(`ISR_ADDR_PSTATE, 32'h5a);
    // one halted thread keeps core awake
    reqm(8'h01, 1'b0, 4'h0, 4'h0);
    chk("core0 one halt", 32'(core_state_o[1:0]), 32'h0);
    chk("repartition", 32'(rp_q), 32'h1);
    reqm(8'h02, 1'b0, 4'h0, 4'h0);
    chk("core0 halt", 32'(core_state_o[1:0]), 32'h1);
    chk("pkg one c0", 32'(pkg_state_o), 32'h0);
    chk("core0 inactive", 32'(core_active_o[0]), 32'h0);
    reqm(8'h0c, 1'b1, `ISR_HINT_C1, `ISR_HINT_C1E_SUB);
    chk("core1 hint c1e", 32'(core_state_o[3:2]), 32'h2);
    // idle to idle is not allowed
    reqm(8'h01, 1'b1, `ISR_HINT_C3, 4'h0);
    chk("core0 no idle hop", 32'(core_state_o[1:0]), 32'h1);
    @(posedge clk_i);
    intr_i <= 8'h01;
    tick(4);
    chk("masked intr", 32'(thr_sleep_o[0]), 32'h1);
    @(posedge clk_i);
    intr_unmasked_i <= 8'hff;
    tick(3);
    chk("intr wake", 32'(thr_sleep_o[0]), 32'h0);
    chk("wake active", 32'(core_active_o[0]), 32'h1);
    @(posedge clk_i);
    intr_i <= 8'hff;
    tick(3);
    chk("all awake", 32'(thr_sleep_o), 32'h0);
    @(posedge clk_i);
    intr_i <= 8'h00;
    // config turns every halt into c1e
    wb(1'b1, `ISR_ADDR_CTRL, 32'h1);
    reqm(8'hff, 1'b0, 4'h0, 4'h0);
    chk("all c1e", 32'(core_state_o), 32'haa);
    chk("min vf", 32'(vf_min_o), 32'h1);
    @(posedge clk_i);
    intr_i <= 8'hff;
    tick(3);
    chk("c1e wake", 32'(core_state_o), 32'h0);
    @(posedge clk_i);
    intr_i <= 8'h00;
    wb(1'b1, `ISR_ADDR_CTRL, 32'h0);
    // deep hint demotes, cores flush, package retains
    reqm(8'hff, 1'b1, 4'h9, 4'h0);
    wt(0);
    chk("demote c3", 32'(core_state_o), 32'hff);
    chk("flushing", 32'(flush_req_o), 32'hf);
    chk("no early retention", 32'(vret_o), 32'h0);
    chk("pkg c3", 32'(pkg_state_o), 32'h3);
    wt(2);
    chk("retention", 32'(vret_o), 32'h1);
    chk("flush finished", 32'(flush_req_o), 32'h0);
    @(posedge clk_i);
    break_masked_i <= 4'h1;
    break_i        <= 4'h1;
    // masked break never shows on the forward lines: track relock instead
    wt(3);
    wt(4);
    @(posedge clk_i);
    break_i <= 4'h0;
    wt(2);
    chk("masked break", 32'(core_state_o[1:0]), 32'h3);
    @(posedge clk_i);
    break_masked_i <= 4'h0;
    break_i        <= 4'h1;
    wt(1);
    @(posedge clk_i);
    break_i <= 4'h0;
    tick(4);
    chk("break wake", 32'(core_state_o[1:0]), 32'h0);
    chk("c3 wake active", 32'(core_active_o[0]), 32'h1);
    chk("resume pstate", 32'(resume_pstate_o), 32'h5a);
    chk("voltage up", 32'(vret_o), 32'h0);
    // level reads: base 0x0400 means c2, range one level
    wb(1'b1, `ISR_ADDR_IOCAP, 32'h0001_0400);
    io(1'b1, 16'h0401, 1'b0);
    io(1'b0, 16'h0402, 1'b0);
    io(1'b0, 16'h0401, 1'b1);
    // low clock enable must ignore a halt
    @(posedge clk_i);
    ce_i <= 1'b0;
    reqm(8'h01, 1'b0, 4'h0, 4'h0);
    chk("ce freeze", 32'(thr_sleep_o[0]), 32'h0);
    @(posedge clk_i);
    ce_i <= 1'b1;
    give_verdict;
end
initial
begin
    #1000000;
    fails++;
    give_verdict;
end
endmodule
`default_nettype wire
